// File: shared/dtp_regs.svh
// register offsets, field positions, reset values and phase counts of the timer pair
`ifndef DTP_REGS_SVH
`define DTP_REGS_SVH

// ************************************************************
// register offsets on the plain register port
// ************************************************************
`define DTP_CPU_STATUS_ADR 8'h06
`define DTP_CORE_INT_ADR 8'h07
`define DTP_FIRST_COUNT_ADR 8'h10
`define DTP_SECOND_COUNT_ADR 8'h11
`define DTP_FIRST_PERIOD_ADR 8'h14
`define DTP_SECOND_PERIOD_ADR 8'h15
`define DTP_CONFIG_ONE_ADR 8'h16
`define DTP_CONFIG_TWO_ADR 8'h17
`define DTP_FLAGS_ONE_ADR 8'h26
`define DTP_ENABLES_ONE_ADR 8'h27

// ************************************************************
// field positions
// ************************************************************
`define DTP_GDIS_BIT 4
`define DTP_PEND_BIT 7
`define DTP_PERIPH_EN_BIT 3
`define DTP_CASCADE_BIT 3
`define DTP_CS2_BIT 1
`define DTP_CS1_BIT 0
`define DTP_ON2_BIT 1
`define DTP_ON1_BIT 0
`define DTP_WRAP2_BIT 5
`define DTP_WRAP1_BIT 4

// ************************************************************
// reset values and timing counts
// ************************************************************
`define DTP_FLAGS_OTHER 8'h02
`define DTP_GDIS_RST 1'b1
`define DTP_INS_LAST 2'h3
`define DTP_HALF_FIRST 2'h1

`endif

// File: shared/dtp_pkg.sv
// types shared by the timer pair modules
package dtp_pkg;

  // state of the timer pair core
  typedef struct packed {
    logic [7:0] cnt1;
    logic [7:0] cnt2;
    logic [7:0] per1;
    logic [7:0] per2;
    logic cascade;
    logic cs1;
    logic cs2;
    logic on1;
    logic on2;
    logic flag1;
    logic flag2;
    logic ie1;
    logic ie2;
    logic periph_en;
    logic gdis;
    logic pin_prev;
    logic [7:0] rdata;
    logic irq;
  } dtp_state_t;

  // two flop synchroniser state
  typedef struct packed {
    logic q1;
    logic q2;
  } dtp_sync_t;

  // instruction cycle phase state
  typedef struct packed {
    logic [1:0] phase;
  } dtp_phase_t;

endpackage

// File: logic/dtp_sync.sv
// two flop synchroniser for the external count pin
module dtp_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  dtp_pkg::dtp_sync_t st_reg; // current stages
  dtp_pkg::dtp_sync_t st_next; // next stages

  // first stage feeds only the second
  always_comb begin
    st_next.q1 = d;
    st_next.q2 = st_reg.q1;
  end

  // both stages clear on reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign q = st_reg.q2;

endmodule

// File: logic/dtp_phase.sv
// instruction cycle phase generator: four core clocks per instruction cycle
`include "dtp_regs.svh"
module dtp_phase (
  input wire logic clk,
  input wire logic rst_n,
  output logic ins_tick,
  output logic half_tick
);

  dtp_pkg::dtp_phase_t st_reg; // current phase
  dtp_pkg::dtp_phase_t st_next; // next phase

  // free running modulo four count
  always_comb begin
    st_next.phase = 2'(st_reg.phase + 2'h1);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // one pulse per instruction cycle, two per cycle for the fast sampler
  assign ins_tick = (st_reg.phase == `DTP_INS_LAST);
  assign half_tick = (st_reg.phase == `DTP_INS_LAST) || (st_reg.phase == `DTP_HALF_FIRST);

endmodule

// File: logic/dtp_timer_pair.sv
// two 8-bit period timers that can be cascaded into one 16-bit timer
`include "dtp_regs.svh"

// Notes on behaviour
// - cascade clear: two independent 8-bit timers
// - source clear: count every instruction cycle
// - source set: count external pin falling edges
// - count to period, then wrap to zero
// - each wrap latches its own flag
// - irq needs enable, peripheral enable, global enabled
// - run bit clear: no count, no flag
// - external pin synchronised before counting
// - cascade: 16-bit count, period, first flag
// - cascade: first source select drives both
// - cascade needs both run bits set
// - cascade external: sample pin twice per cycle
// - counts and periods survive warm reset
module dtp_timer_pair (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic WARM_RST,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic COUNT_PIN,
  output logic IRQ
);

  // ************************************************************
  // constants and helpers
  // ************************************************************

  // power-on value: global interrupts start disabled, rest clear
  localparam dtp_pkg::dtp_state_t ST_RST = '{
    cnt1: 8'h00,
    cnt2: 8'h00,
    per1: 8'h00,
    per2: 8'h00,
    cascade: 1'b0,
    cs1: 1'b0,
    cs2: 1'b0,
    on1: 1'b0,
    on2: 1'b0,
    flag1: 1'b0,
    flag2: 1'b0,
    ie1: 1'b0,
    ie2: 1'b0,
    periph_en: 1'b0,
    gdis: `DTP_GDIS_RST,
    pin_prev: 1'b0,
    rdata: 8'h00,
    irq: 1'b0
  };

  // address decode used for every register write
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // next value of an 8-bit timer: wrap to zero once it equals period
  function automatic logic [7:0] step8(input logic [7:0] c, input logic [7:0] p);
    if (c == p) begin
      step8 = 8'h00;
    end else begin
      step8 = 8'(c + 8'h01);
    end
  endfunction

  // ************************************************************
  // state
  // ************************************************************

  dtp_pkg::dtp_state_t st_reg; // all registered state
  dtp_pkg::dtp_state_t st_next; // its next value

  logic pin_sync; // pin after two flops
  logic ins_tick; // one pulse per instruction cycle
  logic half_tick; // two pulses per instruction cycle
  logic sample; // pin sample strobe
  logic fall; // sampled falling edge on the pin
  logic src1; // first timer clock event
  logic src2; // second timer clock event
  logic adv1; // first timer advances
  logic adv2; // second timer advances
  logic wrap1; // first timer wraps this cycle
  logic wrap2; // second timer wraps this cycle
  logic [15:0] joined; // cascaded count
  logic [15:0] joined_per; // cascaded period
  logic [15:0] joined_step; // cascaded next count
  logic [7:0] nc1; // first count after counting
  logic [7:0] nc2; // second count after counting
  logic pend; // some enabled flag is set
  logic wr_flags; // write to the flag register

  // ************************************************************
  // pin synchroniser and phase generator
  // ************************************************************

  // pin comes from outside, so two flops before any use
  dtp_sync u_sync (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .d(COUNT_PIN),
    .q(pin_sync)
  );

  // instruction cycle is four core clocks
  dtp_phase u_phase (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ins_tick(ins_tick),
    .half_tick(half_tick)
  );

  // ************************************************************
  // clock event selection
  // ************************************************************

  // sample strobe for the pin
  always_comb begin
    // cascaded external counting samples the pin twice per cycle
    if (st_reg.cascade && st_reg.cs1) begin
      sample = half_tick;
    end else begin
      // independent timers sample once per instruction cycle
      sample = ins_tick;
    end
    // falling edge seen between two samples
    fall = sample && st_reg.pin_prev && !pin_sync;
  end

  // per timer clock event
  always_comb begin
    // source select clear: instruction cycle, set: pin edge
    src1 = st_reg.cs1 ? fall : ins_tick;
    // in cascade the second select is a don't care
    if (st_reg.cascade) begin
      src2 = src1;
    end else begin
      src2 = st_reg.cs2 ? fall : ins_tick;
    end
  end

  // ************************************************************
  // counting
  // ************************************************************

  // next counts and wrap events for both modes
  always_comb begin
    joined = {st_reg.cnt2, st_reg.cnt1};
    joined_per = {st_reg.per2, st_reg.per1};
    // cascaded step wraps once it matches the joined period
    if (joined == joined_per) begin
      joined_step = 16'h0000;
    end else begin
      joined_step = 16'(joined + 16'h0001);
    end
    // run bits gate every count; stopped timers keep their value
    adv1 = st_reg.on1 && src1;
    adv2 = st_reg.on2 && src2;
    nc1 = st_reg.cnt1;
    nc2 = st_reg.cnt2;
    wrap1 = 1'b0;
    wrap2 = 1'b0;
    if (!st_reg.cascade) begin
      // two independent 8-bit timers
      if (adv1) begin
        nc1 = step8(st_reg.cnt1, st_reg.per1);
        wrap1 = (st_reg.cnt1 == st_reg.per1);
      end
      if (adv2) begin
        nc2 = step8(st_reg.cnt2, st_reg.per2);
        wrap2 = (st_reg.cnt2 == st_reg.per2);
      end
    end else if (adv1 && st_reg.on2) begin
      // both run bits set: whole 16-bit timer counts
      nc1 = joined_step[7:0];
      nc2 = joined_step[15:8];
      // a cascaded wrap raises only the first flag
      wrap1 = (joined == joined_per);
    end else if (adv1) begin
      // second run bit clear: only the low byte counts, no carry
      nc1 = 8'(st_reg.cnt1 + 8'h01);
    end
  end

  // ************************************************************
  // interrupt request
  // ************************************************************

  // any enabled flag; also the peripheral pending bit
  always_comb begin
    pend = (st_reg.flag1 && st_reg.ie1) || (st_reg.flag2 && st_reg.ie2);
  end

  // ************************************************************
  // register writes, flag updates and read data
  // ************************************************************

  // one next-state process for the whole block
  always_comb begin
    st_next = st_reg;
    wr_flags = WR && hit(ADDR, `DTP_FLAGS_ONE_ADR);

    // counting result; a software write below takes priority
    st_next.cnt1 = nc1;
    st_next.cnt2 = nc2;

    // pin history only moves on the sample strobe
    if (sample) begin
      st_next.pin_prev = pin_sync;
    end

    // register writes
    if (WR) begin
      if (hit(ADDR, `DTP_FIRST_COUNT_ADR)) begin
        st_next.cnt1 = WDATA;
      end
      if (hit(ADDR, `DTP_SECOND_COUNT_ADR)) begin
        st_next.cnt2 = WDATA;
      end
      if (hit(ADDR, `DTP_FIRST_PERIOD_ADR)) begin
        st_next.per1 = WDATA;
      end
      if (hit(ADDR, `DTP_SECOND_PERIOD_ADR)) begin
        st_next.per2 = WDATA;
      end
      if (hit(ADDR, `DTP_CONFIG_ONE_ADR)) begin
        st_next.cascade = WDATA[`DTP_CASCADE_BIT];
        st_next.cs2 = WDATA[`DTP_CS2_BIT];
        st_next.cs1 = WDATA[`DTP_CS1_BIT];
      end
      if (hit(ADDR, `DTP_CONFIG_TWO_ADR)) begin
        st_next.on2 = WDATA[`DTP_ON2_BIT];
        st_next.on1 = WDATA[`DTP_ON1_BIT];
      end
      if (hit(ADDR, `DTP_ENABLES_ONE_ADR)) begin
        st_next.ie2 = WDATA[`DTP_WRAP2_BIT];
        st_next.ie1 = WDATA[`DTP_WRAP1_BIT];
      end
      if (hit(ADDR, `DTP_CORE_INT_ADR)) begin
        st_next.periph_en = WDATA[`DTP_PERIPH_EN_BIT];
      end
      if (hit(ADDR, `DTP_CPU_STATUS_ADR)) begin
        st_next.gdis = WDATA[`DTP_GDIS_BIT];
      end
    end

    // sticky flags: write one clears, a wrap in the same cycle wins
    st_next.flag1 = wrap1 || (st_reg.flag1 && !(wr_flags && WDATA[`DTP_WRAP1_BIT]));
    st_next.flag2 = wrap2 || (st_reg.flag2 && !(wr_flags && WDATA[`DTP_WRAP2_BIT]));

    // interrupt gated by enables and the global disable
    st_next.irq = pend && st_reg.periph_en && !st_reg.gdis;

    // read data stands only in the cycle after the strobe
    st_next.rdata = 8'h00;
    if (RD) begin
      case (ADDR)
        `DTP_FIRST_COUNT_ADR: begin
          st_next.rdata = st_reg.cnt1;
        end
        `DTP_SECOND_COUNT_ADR: begin
          st_next.rdata = st_reg.cnt2;
        end
        `DTP_FIRST_PERIOD_ADR: begin
          st_next.rdata = st_reg.per1;
        end
        `DTP_SECOND_PERIOD_ADR: begin
          st_next.rdata = st_reg.per2;
        end
        `DTP_CONFIG_ONE_ADR: begin
          st_next.rdata[`DTP_CASCADE_BIT] = st_reg.cascade;
          st_next.rdata[`DTP_CS2_BIT] = st_reg.cs2;
          st_next.rdata[`DTP_CS1_BIT] = st_reg.cs1;
        end
        `DTP_CONFIG_TWO_ADR: begin
          st_next.rdata[`DTP_ON2_BIT] = st_reg.on2;
          st_next.rdata[`DTP_ON1_BIT] = st_reg.on1;
        end
        `DTP_FLAGS_ONE_ADR: begin
          // bits of other peripherals read at their reset value
          st_next.rdata = `DTP_FLAGS_OTHER;
          st_next.rdata[`DTP_WRAP2_BIT] = st_reg.flag2;
          st_next.rdata[`DTP_WRAP1_BIT] = st_reg.flag1;
        end
        `DTP_ENABLES_ONE_ADR: begin
          st_next.rdata[`DTP_WRAP2_BIT] = st_reg.ie2;
          st_next.rdata[`DTP_WRAP1_BIT] = st_reg.ie1;
        end
        `DTP_CORE_INT_ADR: begin
          st_next.rdata[`DTP_PEND_BIT] = pend;
          st_next.rdata[`DTP_PERIPH_EN_BIT] = st_reg.periph_en;
        end
        `DTP_CPU_STATUS_ADR: begin
          st_next.rdata[`DTP_GDIS_BIT] = st_reg.gdis;
        end
        default: begin
          // unmapped addresses read as zero
          st_next.rdata = 8'h00;
        end
      endcase
    end

    // warm reset clears control but keeps counts and periods
    if (WARM_RST) begin
      st_next = ST_RST;
      st_next.cnt1 = st_reg.cnt1;
      st_next.cnt2 = st_reg.cnt2;
      st_next.per1 = st_reg.per1;
      st_next.per2 = st_reg.per2;
    end
  end

  // ************************************************************
  // state register
  // ************************************************************

  // power-on reset gives the counts a fixed value instead of an unknown one
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ************************************************************
  // outputs, straight from flops
  // ************************************************************

  assign RDATA = st_reg.rdata;
  assign IRQ = st_reg.irq;

endmodule

// File: tb/dtp_timer_pair_props.sv
// concurrent checks on the ports of the timer pair
module dtp_timer_pair_props (
  input logic CORE_CLK,
  input logic RST_N,
  input logic WARM_RST,
  input logic [7:0] ADDR,
  input logic [7:0] WDATA,
  input logic WR,
  input logic RD,
  input logic [7:0] RDATA,
  input logic COUNT_PIN,
  input logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // shadow of software writes
  // ************************************************************
  logic [7:0] per1_reg; // last first period written
  logic periph_en_reg; // peripheral enable
  logic gdis_reg; // global disable, set out of reset
  logic run1_reg;
  logic run2_reg;
  // warm reset clears control but keeps the period, like the block
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      per1_reg <= 8'h00;
      {periph_en_reg, gdis_reg, run1_reg, run2_reg} <= 4'h4;
    end else if (WARM_RST) begin
      {periph_en_reg, gdis_reg, run1_reg, run2_reg} <= 4'h4;
    end else if (WR) begin
      if (ADDR == 8'h14) per1_reg <= WDATA;
      if (ADDR == 8'h07) periph_en_reg <= WDATA[3];
      if (ADDR == 8'h06) gdis_reg <= WDATA[4];
      if (ADDR == 8'h17) {run2_reg, run1_reg} <= WDATA[1:0];
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);
  period_rb_a: assert property (RD && ADDR == 8'h14 |=> RDATA == per1_reg)
    else $error("period readback differs");
  // the earliest read strobe lands two edges after the warm reset edge
  warm_keep_a: assert property (
    $past(WARM_RST, 2) && RD && ADDR == 8'h14 |=> RDATA == per1_reg)
    else $error("period lost over warm reset");
  irq_gate_a: assert property (
    (gdis_reg || !periph_en_reg) && $past(gdis_reg || !periph_en_reg) |-> !IRQ)
    else $error("interrupt while gated off");
  irq_cause_a: assert property ($rose(IRQ) |-> $past(periph_en_reg && !gdis_reg))
    else $error("interrupt rose without enables");
  warm_irq_a: assert property (WARM_RST |-> ##2 !IRQ)
    else $error("interrupt kept after warm reset");
  hold_count_a: assert property (
    RD && ADDR == 8'h10 && !run1_reg ##2 RD && ADDR == 8'h10 |=> RDATA == $past(RDATA, 2))
    else $error("stopped count moved");
  flag_hold_a: assert property (
    RD && ADDR == 8'h26 && !run1_reg && !run2_reg ##2
    RD && ADDR == 8'h26 |=> RDATA == $past(RDATA, 2))
    else $error("flag changed while stopped");
  flag_layout_a: assert property (RD && ADDR == 8'h26 |=> (RDATA & 8'hCF) == 8'h02)
    else $error("flag register layout wrong");
  cover property (WARM_RST ##2 RD && ADDR == 8'h14);
  cover property ($rose(IRQ));
  cover property ($fell(COUNT_PIN) ##[1:20] RD);
endmodule

// File: tb/dtp_pin_src.sv
// external pulse source on the shared count pin
module dtp_pin_src #(
  parameter int HALF = 10
) (
  input logic clk,
  input logic rst_n,
  input logic go,
  input logic [3:0] num,
  output logic pin,
  output logic busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] left_reg; // level changes still due
  logic [3:0] tmr_reg; // clocks left in this level
  // each level stands HALF+1 clocks, over two instruction cycles
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= 1'b1; // idle high, pulled up
      busy <= 1'b0;
      left_reg <= 5'h00;
      tmr_reg <= 4'h0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      left_reg <= {num, 1'b0};
      tmr_reg <= HALF[3:0];
    end else if (busy && tmr_reg != 4'h0) begin
      tmr_reg <= tmr_reg - 4'h1;
    end else if (busy) begin
      pin <= ~pin;
      tmr_reg <= HALF[3:0];
      left_reg <= left_reg - 5'h01;
      busy <= (left_reg != 5'h01);
    end
  end
endmodule

// File: tb/tb_dual_8bit_timer_pair.sv
// self-checking bench for the timer pair
module tb_dual_8bit_timer_pair;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk, rst_n, warm_rst, wr, rd, go, busy, irq, count_pin;
  logic [7:0] addr, wdata, rdata, p1, c1;
  logic [3:0] num;
  int seed = 89941;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  logic [7:0] v [4];
  // reset table: address and value after power-on
  logic [7:0] ra [7] = '{8'h06, 8'h07, 8'h16, 8'h17, 8'h26, 8'h27, 8'h00};
  logic [7:0] rv [7] = '{8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00};
  logic [7:0] wa [4] = '{8'h14, 8'h10, 8'h11, 8'h15};

  dtp_timer_pair DUT (.CORE_CLK(core_clk), .RST_N(rst_n), .WARM_RST(warm_rst), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .COUNT_PIN(count_pin), .IRQ(irq));
  dtp_pin_src #(.HALF(10)) u_src (.clk(core_clk), .rst_n(rst_n), .go(go), .num(num),
    .pin(count_pin), .busy(busy));

  // ************************************************************
  // clock, hang guard and helpers
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // the whole run needs under 6000 cycles
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      give_verdict();
    end
  end
  // count value after some ticks from a start below the period
  function automatic int nxt(input int s, input int t, input int p);
    return (s + t) % (p + 1);
  endfunction
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] val);
    @(posedge core_clk);
    addr <= a;
    wdata <= val;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  // data stand in the cycle after the strobe only
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] val);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 val = rdata;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] got;
    rd_reg(a, got);
    chk(got, exp);
  endtask
  // interrupt output lags its cause by one cycle
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge core_clk);
    #1 chk({7'h00, irq}, {7'h00, e});
  endtask
  // run bits on for exactly 4*ticks clocks, so exactly ticks increments
  task automatic run_for(input logic [7:0] on, input int ticks);
    wr_reg(8'h17, on);
    repeat (4 * ticks - 2) @(posedge core_clk);
    wr_reg(8'h17, 8'h00);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {rst_n, warm_rst, wr, rd, go, addr, wdata, num} = '0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    foreach (ra[i]) rd_chk(ra[i], rv[i]);
    // random counts and periods survive a warm reset, control does not
    foreach (wa[i]) begin
      v[i] = 8'($random(seed));
      wr_reg(wa[i], v[i]);
    end
    wr_reg(8'h16, 8'h0B);
    @(posedge core_clk);
    warm_rst <= 1'b1;
    @(posedge core_clk);
    warm_rst <= 1'b0;
    foreach (wa[i]) rd_chk(wa[i], v[i]);
    rd_chk(8'h16, 8'h00);
    // two independent timers on the instruction clock
    p1 = 8'h03 + 8'($random(seed) & 7);
    wr_reg(8'h14, p1);
    wr_reg(8'h15, 8'hFF);
    wr_reg(8'h10, 8'h00);
    wr_reg(8'h11, 8'h00);
    n = 20 + ($random(seed) & 15);
    run_for(8'h03, n);
    rd_chk(8'h10, 8'(nxt(0, n, p1)));
    rd_chk(8'h11, 8'(nxt(0, n, 255)));
    rd_chk(8'h26, 8'h12);
    // interrupt gating, masking and clearing
    wr_reg(8'h27, 8'h10);
    wr_reg(8'h07, 8'h08);
    irq_chk(1'b0);
    wr_reg(8'h06, 8'h00);
    irq_chk(1'b1);
    rd_chk(8'h07, 8'h88);
    wr_reg(8'h27, 8'h00);
    irq_chk(1'b0);
    wr_reg(8'h27, 8'h10);
    wr_reg(8'h26, 8'h10);
    irq_chk(1'b0);
    // stopped timers raise no flag and the first holds, then resumes
    rd_reg(8'h10, c1);
    rd_chk(8'h10, c1);
    repeat (40) @(posedge core_clk);
    rd_chk(8'h10, c1);
    repeat (2) rd_chk(8'h26, 8'h02);
    run_for(8'h01, 5);
    rd_chk(8'h10, 8'(nxt(c1, 5, p1)));
    // cascaded count; the second source select must be ignored
    wr_reg(8'h16, 8'h0A);
    wr_reg(8'h14, 8'h02);
    wr_reg(8'h15, 8'h01);
    wr_reg(8'h10, 8'h00);
    wr_reg(8'h11, 8'h00);
    wr_reg(8'h26, 8'h30);
    n = 260 + ($random(seed) & 31);
    run_for(8'h03, n);
    rd_chk(8'h10, 8'(nxt(0, n, 258)));
    rd_chk(8'h11, 8'(nxt(0, n, 258) >> 8));
    rd_chk(8'h26, 8'h12);
    // cascade with one or the other run bit only
    wr_reg(8'h10, 8'hF0);
    wr_reg(8'h11, 8'h05);
    wr_reg(8'h26, 8'h30);
    run_for(8'h01, 20);
    run_for(8'h02, 20);
    rd_chk(8'h10, 8'(nxt(240, 20, 255)));
    rd_chk(8'h11, 8'h05);
    rd_chk(8'h26, 8'h02);
    // falling edges on the shared pin, separate then cascaded
    for (int m = 0; m < 2; m++) begin
      wr_reg(8'h16, m ? 8'h09 : 8'h03);
      wr_reg(8'h14, 8'hFF);
      wr_reg(8'h15, 8'hFF);
      wr_reg(8'h10, 8'h00);
      wr_reg(8'h11, 8'h00);
      wr_reg(8'h17, 8'h03);
      n = 1 + ($random(seed) & 7);
      num <= 4'(n);
      go <= 1'b1;
      @(posedge core_clk);
      go <= 1'b0;
      #1;
      for (int k = 0; k < 400 && busy; k++) @(posedge core_clk);
      repeat (16) @(posedge core_clk);
      wr_reg(8'h17, 8'h00);
      rd_chk(8'h10, 8'(n));
      rd_chk(8'h11, m ? 8'h00 : 8'(n));
    end
    give_verdict();
  end
endmodule

bind dtp_timer_pair dtp_timer_pair_props u_props (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
  .WARM_RST(WARM_RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
  .COUNT_PIN(COUNT_PIN), .IRQ(IRQ));
